// [hw/vm_classify.sv]
// compatibility-mode io checker and interrupt classifier
// assumes synchronous one-cycle request pulses from the core pipeline
// Overview of operation
// - port io checked against task permission bitmap
// - bitmap always checked, no privilege shortcut
// - not-present io page raises page fault
// - exceptions and hardware interrupts are class one
// - maskable interrupts class two only with extensions
// - software interrupt instruction gives class three
// - privilege field bits 12-13 steer class three
// - privilege field gates virtual flags under extensions
// - control bit 0 enables virtual mode extensions
// - 256-flag redirection bitmap, 32 bytes
// - redirection flag picks legacy or protected handler
// - virtual flag and pending support class two
// - monitor reached through general protection vector
// - handler picked from class and flags
// - privilege fixed at user level in mode
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module vm_classify
    import vm_classify_pkg::*;
(
    input  wire logic                    CLK,
    input  wire logic                    RSTN,
    input  wire logic [3:0]              ADDR,
    input  wire logic [31:0]             WDATA,
    input  wire logic                    WR,
    input  wire logic                    RD,
    output logic      [31:0]             RDATA,
    input  wire logic                    IO_REQ,
    input  wire logic [6:0]              IO_PORT,
    output logic                         IO_FAULT,
    input  wire logic                    MEM_REQ,
    input  wire logic                    MEM_PAGE_PRESENT,
    input  wire logic                    MEM_IS_IO,
    output logic                         PAGE_FAULT,
    input  wire logic                    EV_REQ,
    input  wire vm_classify_pkg::kind_t  EV_KIND,
    input  wire logic [7:0]              EV_VECTOR,
    output vm_classify_pkg::class_t      EV_CLASS,
    output vm_classify_pkg::dest_t       EV_DEST,
    output logic [7:0]                   EV_OUT_VECTOR,
    output logic                         EV_VALID,
    output logic [1:0]                   CURRENT_PRIVILEGE_LEVEL,
    output logic                         IRQ
);
    import vm_classify_pkg::*;

    logic [31:0]             ctrl;
    logic [31:0]             flags;
    logic [IOPERM_PORTS-1:0] ioperm;
    logic [255:0]            redir;
    logic [ST_WIDTH-1:0]     status;
    logic [ST_WIDTH-1:0]     mask;

    wire       virtual_mode_ext_enable      = ctrl[BIT_VME];
    wire       vmode    = ctrl[BIT_VMODE];
    wire [1:0] io_privilege_level     = {flags[BIT_IOPL1], flags[BIT_IOPL0]};
    wire       io_privilege_level_max = (io_privilege_level == CPL_USER);
    wire       virtual_irq_flag      = flags[BIT_VIF];

    // cpl is forced to user while in compatibility mode
    assign CURRENT_PRIVILEGE_LEVEL = vmode ? CPL_USER : 2'h0;

    // no cpl<=io_privilege_level bypass: a set bit faults regardless of privilege
    wire io_denied = vmode & IO_REQ & ioperm[IO_PORT];
    wire pf_hit    = vmode & MEM_REQ & MEM_IS_IO & ~MEM_PAGE_PRESENT;

    // classification
    wire is_soft  = (EV_KIND == KIND_SOFT);
    wire is_mask  = (EV_KIND == KIND_MASKABLE);
    wire cls_two  = is_mask & virtual_mode_ext_enable;
    wire redir_on = ~redir[EV_VECTOR];
    // virtual flags only act with extensions on and io_privilege_level below user
    wire virt_on  = virtual_mode_ext_enable & ~io_privilege_level_max;

    class_t next_class;
    dest_t  next_dest;
    logic [7:0] next_vec;
    logic       next_gp;
    logic       next_vip;
    always_comb begin
        next_class = CLASS_ONE;
        next_dest  = DEST_PROT;
        next_vec   = EV_VECTOR;
        next_gp    = 1'b0;
        next_vip   = 1'b0;
        if (is_soft) begin
            next_class = CLASS_THREE;
            if (virtual_mode_ext_enable & redir_on) begin
                next_dest = DEST_LEGACY;
            end else if (!io_privilege_level_max) begin
                next_vec = VEC_GP;
                next_gp  = 1'b1;
            end
        end else if (cls_two) begin
            next_class = CLASS_TWO;
            if (virt_on) begin
                next_dest = DEST_VIRT;
                next_vip  = ~virtual_irq_flag;
            end
        end
        if (pf_hit) begin
            next_vec = VEC_PF;
        end
    end

    // register port decode
    wire wr_ctrl   = WR & (ADDR == ADDR_CTRL);
    wire wr_flags  = WR & (ADDR == ADDR_FLAGS);
    wire wr_status = WR & (ADDR == ADDR_STATUS);
    wire wr_mask   = WR & (ADDR == ADDR_MASK);
    wire [2:0] redir_idx = ADDR[2:0];
    wire wr_redir  = WR & (ADDR >= ADDR_REDIR_BASE);
    wire [1:0] perm_idx  = ADDR[1:0];
    wire wr_perm   = WR & (ADDR >= ADDR_IOPERM_LO) & (ADDR < ADDR_REDIR_BASE);

    wire ev_fire = (EV_REQ | pf_hit) & vmode;
    wire [ST_WIDTH-1:0] events = {ev_fire, ev_fire & next_gp, pf_hit, io_denied};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (ADDR == ADDR_CTRL) begin
            rd_mux = ctrl;
        end else if (ADDR == ADDR_FLAGS) begin
            rd_mux = flags;
        end else if (ADDR == ADDR_STATUS) begin
            rd_mux = {{(32-ST_WIDTH){1'b0}}, status};
        end else if (ADDR == ADDR_MASK) begin
            rd_mux = {{(32-ST_WIDTH){1'b0}}, mask};
        end else if (ADDR < ADDR_REDIR_BASE) begin
            rd_mux = ioperm[perm_idx*32 +: 32];
        end else begin
            rd_mux = redir[redir_idx*32 +: 32];
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl   <= RESET_CTRL;
            mask   <= '0;
            ioperm <= '0;
            redir  <= '0;
            RDATA  <= 32'h0;
        end else begin
            if (wr_ctrl) ctrl <= WDATA;
            if (wr_mask) mask <= WDATA[ST_WIDTH-1:0];
            if (wr_perm) ioperm[perm_idx*32 +: 32] <= WDATA;
            if (wr_redir) redir[redir_idx*32 +: 32] <= WDATA;
            RDATA <= RD ? rd_mux : 32'h0;
        end
    end

    // pending flag set by hardware wins over a software write
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            flags <= RESET_FLAGS;
        end else begin
            if (wr_flags) flags <= WDATA;
            if (EV_REQ & vmode & next_vip) flags[BIT_VIP] <= 1'b1;
        end
    end

    // sticky status, set beats write-one-clear
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            status <= '0;
        end else begin
            status <= (status & ~(wr_status ? WDATA[ST_WIDTH-1:0] : '0)) | events;
        end
    end
    assign IRQ = |(status & mask);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            IO_FAULT      <= 1'b0;
            PAGE_FAULT    <= 1'b0;
            EV_VALID      <= 1'b0;
            EV_CLASS      <= CLASS_NONE;
            EV_DEST       <= DEST_NONE;
            EV_OUT_VECTOR <= 8'h0;
        end else begin
            IO_FAULT   <= io_denied;
            PAGE_FAULT <= pf_hit;
            EV_VALID   <= ev_fire;
            if (ev_fire) begin
                EV_CLASS      <= pf_hit ? CLASS_ONE : next_class;
                EV_DEST       <= pf_hit ? DEST_PROT : next_dest;
                EV_OUT_VECTOR <= next_vec;
            end
        end
    end
endmodule // vm_classify

// [hw/vm_classify_pkg.sv]
// constants for the compatibility-mode io and interrupt classifier
// assumes a single core clock domain and a plain register port
package vm_classify_pkg;
    // register indices on the plain port
    localparam logic [3:0] ADDR_CTRL       = 4'h0;
    localparam logic [3:0] ADDR_FLAGS      = 4'h1;
    localparam logic [3:0] ADDR_STATUS     = 4'h2;
    localparam logic [3:0] ADDR_MASK       = 4'h3;
    localparam logic [3:0] ADDR_IOPERM_LO  = 4'h4;
    localparam logic [3:0] ADDR_REDIR_BASE = 4'h8;
    localparam int         REDIR_WORDS     = 8;
    localparam int         IOPERM_PORTS    = 128;
    // field positions
    localparam int BIT_VME    = 0;
    localparam int BIT_VMODE  = 1;
    localparam int BIT_IOPL0  = 12;
    localparam int BIT_IOPL1  = 13;
    localparam int BIT_VIF    = 19;
    localparam int BIT_VIP    = 20;
    // status bits
    localparam int ST_IO_FAULT   = 0;
    localparam int ST_PAGE_FAULT = 1;
    localparam int ST_GP_FAULT   = 2;
    localparam int ST_EVENT      = 3;
    localparam int ST_WIDTH      = 4;
    localparam logic [31:0] RESET_CTRL  = 32'h0000_0000;
    localparam logic [31:0] RESET_FLAGS = 32'h0000_0000;
    localparam logic [1:0]  CPL_USER    = 2'h3;
    localparam logic [7:0]  VEC_GP      = 8'h0d;
    localparam logic [7:0]  VEC_PF      = 8'h0e;
    typedef enum logic [1:0] {CLASS_NONE, CLASS_ONE, CLASS_TWO, CLASS_THREE} class_t;
    typedef enum logic [1:0] {DEST_NONE, DEST_PROT, DEST_LEGACY, DEST_VIRT} dest_t;
    typedef enum logic [1:0] {KIND_EXC, KIND_HWINT, KIND_MASKABLE, KIND_SOFT} kind_t;
endpackage

// [verif/vm_classify_chk.sv]
// port assertions for the io and interrupt classifier
// assumes it is bound onto vm_classify, one clock domain
`timescale 1ns/1ps
module vm_classify_chk
    import vm_classify_pkg::*;
(
    input wire logic                   CLK,
    input wire logic                   RSTN,
    input wire logic                   IO_REQ,
    input wire logic                   IO_FAULT,
    input wire logic                   MEM_REQ,
    input wire logic                   MEM_PAGE_PRESENT,
    input wire logic                   MEM_IS_IO,
    input wire logic                   PAGE_FAULT,
    input wire logic                   EV_REQ,
    input wire vm_classify_pkg::kind_t  EV_KIND,
    input wire vm_classify_pkg::class_t EV_CLASS,
    input wire vm_classify_pkg::dest_t  EV_DEST,
    input wire logic                   EV_VALID,
    input wire logic [1:0]             CURRENT_PRIVILEGE_LEVEL
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // page fault outranks a same-cycle event, so leave those out
    wire go  = EV_REQ && CURRENT_PRIVILEGE_LEVEL == CPL_USER && !MEM_REQ;
    wire bad = MEM_REQ && CURRENT_PRIVILEGE_LEVEL == CPL_USER && MEM_IS_IO && !MEM_PAGE_PRESENT;
    property p_io; IO_FAULT |-> $past(IO_REQ) && $past(CURRENT_PRIVILEGE_LEVEL) == CPL_USER; endproperty
    a_io: assert property (p_io) else $error("io fault without request");
    property p_pf; bad |=> PAGE_FAULT; endproperty
    a_pf: assert property (p_pf) else $error("page fault missing");
    property p_pf2; PAGE_FAULT |-> $past(bad); endproperty
    a_pf2: assert property (p_pf2) else $error("page fault without cause");
    property p_c1; go && EV_KIND inside {KIND_EXC, KIND_HWINT} |=> EV_VALID && EV_CLASS == CLASS_ONE && EV_DEST == DEST_PROT; endproperty
    a_c1: assert property (p_c1) else $error("class one routing wrong");
    property p_c2; go && EV_KIND == KIND_MASKABLE |=> EV_VALID && EV_CLASS != CLASS_THREE && EV_DEST != DEST_LEGACY; endproperty
    a_c2: assert property (p_c2) else $error("maskable routing wrong");
    property p_c3; go && EV_KIND == KIND_SOFT |=> EV_VALID && EV_CLASS == CLASS_THREE && EV_DEST != DEST_VIRT; endproperty
    a_c3: assert property (p_c3) else $error("soft interrupt not class three");
    property p_off; EV_REQ && CURRENT_PRIVILEGE_LEVEL != CPL_USER |=> !EV_VALID; endproperty
    a_off: assert property (p_off) else $error("event outside mode");
    // a not-present io page also reports an event, so it is left out here
    property p_hold; !EV_REQ && !bad |=> !EV_VALID && $stable(EV_CLASS) && $stable(EV_DEST); endproperty
    a_hold: assert property (p_hold) else $error("event result not held");
endmodule // vm_classify_chk

// [verif/vm_classify_test.sv]
// self-checking bench for the io and interrupt classifier
// assumes vm_classify and its checker are compiled first
`timescale 1ns/1ps
`define CHK(n, x, y) begin samples_checked++; if ((y) !== (x)) begin $display("[ERR] %s exp %h got %h", n, x, y); mismatches++; end end
module vm_classify_test;
    import vm_classify_pkg::*;
    logic         CLK = 1'b0, RSTN = 1'b0, MEM_PAGE_PRESENT = 1'b0, MEM_IS_IO = 1'b0;
    logic [4:0]   req = 5'h00;
    logic [3:0]   pend = 4'h0, ADDR = 4'h0;
    logic [31:0]  WDATA = 32'h0, RDATA, e, t;
    logic [6:0]   IO_PORT = 7'h00;
    logic [7:0]   EV_VECTOR = 8'h00, EV_OUT_VECTOR, v;
    kind_t        EV_KIND = KIND_EXC;
    class_t       EV_CLASS;
    dest_t        EV_DEST;
    logic         IO_FAULT, PAGE_FAULT, EV_VALID, IRQ;
    logic [1:0]   CURRENT_PRIVILEGE_LEVEL;
    logic [127:0] perm;
    logic [255:0] redir;
    logic [31:0]  notes[$];
    int           mismatches = 0, samples_checked = 0;
    wire  [12:0]  ev_seen = {EV_VALID, EV_VALID ? {EV_CLASS, EV_DEST, EV_OUT_VECTOR} : 12'h000};
    vm_classify u_vm_classify (.*, .WR(req[4]), .RD(req[3]), .IO_REQ(req[2]), .MEM_REQ(req[1]), .EV_REQ(req[0]));
    always #10 CLK = ~CLK;
    // results land one cycle after the request, so judge them mid-cycle
    always @(posedge CLK) pend <= req[3:0];
    always @(negedge CLK) begin
        if (pend != 4'h0) begin
            e = notes.pop_front();
            if (pend[3]) `CHK("rdata", e, RDATA)
            if (pend[2]) `CHK("io_fault", e[0], IO_FAULT)
            if (pend[1]) `CHK("page_fault", e[0], PAGE_FAULT)
            if (pend[0]) `CHK("event", e[12:0], ev_seen)
        end
    end
    function automatic logic [31:0] ev(input logic [1:0] c, input logic [1:0] d, input logic [7:0] vv);
        return {19'h0, 1'b1, c, d, vv};
    endfunction
    // one request per call, a free cycle after it
    task automatic drive(input logic [4:0] k, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x);
        @(posedge CLK);
        req <= k;
        ADDR <= a[3:0];
        IO_PORT <= a[6:0];
        EV_VECTOR <= a;
        WDATA <= d;
        EV_KIND <= kind_t'(d[1:0]);
        MEM_IS_IO <= d[1];
        MEM_PAGE_PRESENT <= d[0];
        if (k != 5'h10) notes.push_back(x);
        @(posedge CLK);
        req <= 5'h00;
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        test_done();
    end
    initial begin
        void'($urandom(78356));
        repeat (10) @(posedge CLK);
        RSTN <= 1'b1;
        drive(5'h08, 8'(ADDR_CTRL), 0, RESET_CTRL);
        drive(5'h01, 8'h21, 3, 0);
        drive(5'h10, 8'(ADDR_CTRL), 32'h3, 0);
        drive(5'h08, 8'(ADDR_CTRL), 0, 32'h3);
        `CHK("cpl", CPL_USER, CURRENT_PRIVILEGE_LEVEL)
        drive(5'h10, 8'(ADDR_FLAGS), 32'h3000, 0);
        drive(5'h10, 8'(ADDR_IOPERM_LO), 32'h1, 0);
        drive(5'h10, 8'(ADDR_MASK), 32'h1, 0);
        drive(5'h04, 8'h00, 0, 32'h1);
        @(negedge CLK);
        `CHK("irq", 1'b1, IRQ)
        drive(5'h10, 8'(ADDR_MASK), 32'h0, 0);
        @(negedge CLK);
        `CHK("irq", 1'b0, IRQ)
        drive(5'h10, 8'(ADDR_STATUS), 32'h1, 0);
        drive(5'h10, 8'(ADDR_MASK), 32'h1, 0);
        @(negedge CLK);
        `CHK("irq", 1'b0, IRQ)
        for (int i = 0; i < 4; i++) begin
            perm[i*32 +: 32] = $urandom();
            drive(5'h10, 8'(ADDR_IOPERM_LO + i), perm[i*32 +: 32], 0);
        end
        for (int i = 0; i < 16; i++) begin
            v = $urandom();
            drive(5'h04, {1'b0, v[6:0]}, 0, {31'h0, perm[v[6:0]]});
        end
        for (int i = 0; i < 4; i++) drive(5'h02, 0, i, {31'h0, i == 2});
        for (int i = 0; i < 2; i++) begin
            v = $urandom();
            drive(5'h01, v, i, ev(CLASS_ONE, DEST_PROT, v));
        end
        for (int i = 0; i < REDIR_WORDS; i++) begin
            redir[i*32 +: 32] = $urandom();
            drive(5'h10, 8'(ADDR_REDIR_BASE + i), redir[i*32 +: 32], 0);
        end
        // bit 0 of m is the extension enable, the rest the privilege field
        for (int m = 0; m < 8; m++) begin
            drive(5'h10, 8'(ADDR_CTRL), 32'h2 | m[0], 0);
            drive(5'h10, 8'(ADDR_FLAGS), (m / 2) << 12, 0);
            v = $urandom();
            t = (m[0] && !redir[v]) ? ev(CLASS_THREE, DEST_LEGACY, v) : ev(CLASS_THREE, DEST_PROT, m < 6 ? VEC_GP : v);
            drive(5'h01, v, 3, t);
            t = !m[0] ? ev(CLASS_ONE, DEST_PROT, v) : ev(CLASS_TWO, m < 6 ? DEST_VIRT : DEST_PROT, v);
            drive(5'h01, v, 2, t);
            drive(5'h08, 8'(ADDR_FLAGS), 0, ((m / 2) << 12) | ((m[0] && m < 6) ? 32'h0010_0000 : 0));
        end
        test_done();
    end
endmodule // vm_classify_test
bind vm_classify vm_classify_chk u_vm_classify_chk (.*);
